//--- testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ums_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
   logic        cts_n_i, dsr_n_i, ri_n_i, cd_n_i, ir_rx_i, tx_thr_empty_i, tx_idle_i;
   logic        tx_load_i, bit_tick_i, rts_n_o, dtr_n_o, tx_pause_o, tx_int_o;
   logic        modem_int_o, ir_rx_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [5:0]  hyst_chars_o;
   logic [4:0]  want;
   ums_byte_t   q;
   int          errors, samples_checked;
   wire logic [4:0] pins;
   assign {ir_rx_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i} = pins;
   ums_modem_ctrl u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i),
      .ri_n_i(ri_n_i), .cd_n_i(cd_n_i), .ir_rx_i(ir_rx_i), .tx_thr_empty_i(tx_thr_empty_i),
      .tx_idle_i(tx_idle_i), .tx_load_i(tx_load_i), .bit_tick_i(bit_tick_i),
      .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .tx_pause_o(tx_pause_o), .tx_int_o(tx_int_o),
      .modem_int_o(modem_int_o), .ir_rx_o(ir_rx_o), .hyst_chars_o(hyst_chars_o));
   ums_line_model u_line (.clk_i(clk_i), .slow_i(slow), .want_i(want), .pins_o(pins));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ****
   // Helpers
   // ****
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 16);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
         chk("bus ack", wb_ack_o, 8'h01);
         results();
      end
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_regs();
      wb(0, 8'h04, 8'h00);
      chk("scratch reset", q, 8'hFF);
      wb(0, 8'h08, 8'h00);
      chk("feature reset", q, 8'h00);
      wb(1, 8'h04, 8'hA5);
      wb_sel_i <= 4'h0;
      wb(1, 8'h04, 8'h3C);
      wb_sel_i <= 4'hF;
      wb(0, 8'h04, 8'h00);
      chk("scratch rw", q, 8'hA5);
      wb(1, 8'h00, 8'hF0);
      wb(0, 8'h18, 8'h00);
      chk("delay locked", {4'h0, q[3:0]}, 8'h00);
      wb(0, 8'h1C, 8'h00);
      chk("unmapped", q, 8'h00);
      $display("regs done");
   endtask
   task automatic t_flags();
      wb(1, 8'h14, 8'h08);
      wb(0, 8'h00, 8'h00);
      want <= 5'h00;
      step(4);
      chk("modem int", modem_int_o, 8'h01);
      wb(0, 8'h00, 8'h00);
      chk("all fell", q, 8'hFB);
      step(2);
      chk("int cleared", modem_int_o, 8'h00);
      want <= 5'h04;
      step(4);
      wb(0, 8'h00, 8'h00);
      chk("ring end", q, 8'hB4);
      wb(0, 8'h00, 8'h00);
      chk("flags cleared", q, 8'hB0);
      wb(1, 8'h14, 8'h00);
      want <= 5'h0F;
      step(4);
      chk("masked int", modem_int_o, 8'h00);
      wb(0, 8'h00, 8'h00);
      chk("all rose", q, 8'h0B);
      $display("flags done");
   endtask
   task automatic t_loop();
      wb(1, 8'h0C, 8'h1A);
      wb(0, 8'h00, 8'h00);
      chk("loop a", q, 8'h99);
      wb(1, 8'h0C, 8'h15);
      wb(0, 8'h00, 8'h00);
      chk("loop b", q, 8'h6B);
      chk("loop rts", rts_n_o, 8'h01);
      wb(1, 8'h0C, 8'h03);
      step(2);
      chk("dtr out", {rts_n_o, dtr_n_o}, 8'h00);
      wb(0, 8'h00, 8'h00);
      $display("loopback done");
   endtask
   task automatic t_pause();
      slow <= 1'b1;
      wb(1, 8'h0C, 8'h00);
      wb(1, 8'h10, 8'h90);
      step(2);
      chk("cts stop", tx_pause_o, 8'h01);
      want <= 5'h0E;
      step(5);
      chk("cts go", tx_pause_o, 8'h00);
      wb(1, 8'h0C, 8'h04);
      step(2);
      chk("dsr stop", tx_pause_o, 8'h01);
      want <= 5'h0C;
      step(5);
      chk("dsr go", tx_pause_o, 8'h00);
      wb(1, 8'h10, 8'h10);
      wb(1, 8'h0C, 8'h00);
      slow <= 1'b0;
      $display("pause done");
   endtask
   task automatic t_feat();
      want <= 5'h1F;
      tx_thr_empty_i <= 1'b1;
      for (int c = 0; c < 16; c++)
      begin
         wb(1, 8'h08, 8'hC0 | c[7:0]);
         step(2);
      end
      chk("hyst 15", {2'h0, hyst_chars_o}, 8'h24);
      wb(1, 8'h08, 8'h4B);
      step(2);
      chk("hyst off", {2'h0, hyst_chars_o}, 8'h00);
      wb(1, 8'h08, 8'h10);
      step(2);
      chk("ir inverted", ir_rx_o, 8'h00);
      wb(1, 8'h08, 8'h00);
      step(2);
      chk("ir plain", ir_rx_o, 8'h01);
      chk("thr int", tx_int_o, 8'h01);
      $display("feature done");
   endtask
   task automatic t_rs485();
      wb(1, 8'h00, 8'h30);
      wb(0, 8'h18, 8'h00);
      chk("delay field", {4'h0, q[3:0]}, 8'h03);
      wb(1, 8'h08, 8'h20);
      step(2);
      chk("receive dir", rts_n_o, 8'h00);
      chk("tsr int", tx_int_o, 8'h00);
      tx_load_i      <= 1'b1;
      tx_thr_empty_i <= 1'b0;
      step(1);
      tx_load_i <= 1'b0;
      step(1);
      chk("rts at load", rts_n_o, 8'h01);
      tx_thr_empty_i <= 1'b1;
      tx_idle_i      <= 1'b1;
      step(2);
      chk("waiting", rts_n_o, 8'h01);
      chk("tsr empty", tx_int_o, 8'h01);
      for (int k = 1; k <= 3; k++)
      begin
         bit_tick_i <= 1'b1;
         step(1);
         bit_tick_i <= 1'b0;
         step(1);
         chk("turnaround", rts_n_o, (k < 3) ? 8'h01 : 8'h00);
      end
      wb(1, 8'h00, 8'h00);
      tx_load_i <= 1'b1;
      tx_idle_i <= 1'b0;
      step(1);
      tx_load_i <= 1'b0;
      step(2);
      tx_idle_i <= 1'b1;
      step(1);
      chk("no delay a", rts_n_o, 8'h01);
      step(1);
      chk("no delay b", rts_n_o, 8'h00);
      $display("rs485 done");
   endtask
   initial
   begin
      errors = 0;
      samples_checked = 0;
      {rst_i, wb_sel_i, want} = {1'b1, 4'hF, 5'h0F};
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, slow} = '0;
      {tx_thr_empty_i, tx_idle_i, tx_load_i, bit_tick_i} = 4'h0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_flags();
      t_loop();
      t_pause();
      t_feat();
      t_rs485();
      results();
   end
endmodule
bind ums_modem_ctrl ums_properties u_prop (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i),
   .ri_n_i(ri_n_i), .cd_n_i(cd_n_i), .ir_rx_i(ir_rx_i), .tx_thr_empty_i(tx_thr_empty_i),
   .tx_idle_i(tx_idle_i), .tx_load_i(tx_load_i), .rts_n_o(rts_n_o), .tx_pause_o(tx_pause_o),
   .tx_int_o(tx_int_o), .modem_int_o(modem_int_o), .ir_rx_o(ir_rx_o),
   .hyst_chars_o(hyst_chars_o));
`default_nettype wire

//--- ums_consts.svh
`ifndef UMS_CONSTS_SVH
`define UMS_CONSTS_SVH

// Register byte offsets on the bus
`define UMS_ADR_MSTAT   8'h00
`define UMS_ADR_SCRATCH 8'h04
`define UMS_ADR_FEAT    8'h08
`define UMS_ADR_MCTL    8'h0C
`define UMS_ADR_EFEAT   8'h10
`define UMS_ADR_IEN     8'h14
`define UMS_ADR_STAT    8'h18

// Reset values
`define UMS_SCRATCH_RST 8'hFF
`define UMS_BYTE_RST    8'h00
`define UMS_DLY_RST     4'h0

// Field positions
`define UMS_MCTL_DTR    0
`define UMS_MCTL_RTS    1
`define UMS_MCTL_SEL    2
`define UMS_MCTL_OUT3   3
`define UMS_MCTL_LOOP   4
`define UMS_EFEAT_ENH   4
`define UMS_EFEAT_ACTS  7
`define UMS_IEN_MODEM   3
`define UMS_FEAT_IRINV  4
`define UMS_FEAT_RS485  5
`define UMS_FEAT_TBL_HI 7
`define UMS_FEAT_TBL_LO 6
`define UMS_DLY_LO      4
`define UMS_TBL_D       2'h3

// Change flag that only reacts to the status falling (ring end)
`define UMS_FALL_ONLY   4'h4

`endif

//--- ums_delta.sv
`include "ums_consts.svh"
`default_nettype none

module ums_delta
#(
   parameter int               N         = 4,
   parameter logic [N-1:0]     FALL_ONLY = `UMS_FALL_ONLY
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   ums_link_if.dlt   lk
);
   import ums_pkg::*;

   if (N != 4)
   begin : g_chk
      $error("ums_delta serves exactly four modem lines");
   end

   typedef struct packed {
      logic [N-1:0] prev;
      logic [N-1:0] flags;
      logic         primed;
   } ums_dlt_st_t;

   ums_dlt_st_t  q_reg;
   ums_dlt_st_t  q_next;
   logic [N-1:0] ev;

   // Priming avoids a false change right after reset
   for (genvar i = 0; i < N; i++)
   begin : g_line
      assign ev[i] = q_reg.primed & (FALL_ONLY[i] ?
                     (q_reg.prev[i] & ~lk.st[i]) :
                     (q_reg.prev[i] ^ lk.st[i]));
   end

   always_comb
   begin
      q_next        = q_reg;
      q_next.prev   = lk.st;
      q_next.primed = 1'b1;
      // Set wins over a read clear in the same cycle
      q_next.flags  = (q_reg.flags & ~{N{lk.clr}}) | ev;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q_reg <= '0;
      else
         q_reg <= q_next;
   end

   assign lk.dflags = q_reg.flags;

endmodule

`default_nettype wire

//--- ums_line_model.sv
`default_nettype none
module ums_line_model
(
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic [4:0] want_i,
   output var  logic [4:0] pins_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] now_reg = 5'h0F;
   logic [4:0] lag_reg = 5'h0F;
   // Lines move only after an edge, never on it
   always_ff @(posedge clk_i)
   begin
      lag_reg <= want_i;
      now_reg <= slow_i ? lag_reg : want_i;
   end
   assign pins_o = now_reg;
endmodule
`default_nettype wire

//--- ums_link_if.sv
`default_nettype none

interface ums_link_if;
   import ums_pkg::*;

   ums_nib_t        st;
   logic            clr;
   ums_nib_t        dflags;
   logic            t_en;
   ums_nib_t        t_dly;
   logic            t_idle;
   logic            t_load;
   logic            t_tick;
   logic            t_drive;
   ums_turn_state_t t_state;

   modport dlt (input st, input clr, output dflags);
   modport trn (input t_en, input t_dly, input t_idle, input t_load, input t_tick,
                output t_drive, output t_state);
   modport ctl (output st, output clr, input dflags,
                output t_en, output t_dly, output t_idle, output t_load, output t_tick,
                input t_drive, input t_state);
endinterface

`default_nettype wire

//--- ums_modem_ctrl.sv
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`include "ums_consts.svh"
`default_nettype none

module ums_modem_ctrl
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output var  logic [31:0]  wb_dat_o,
   output var  logic         wb_ack_o,
   input  wire logic         cts_n_i,
   input  wire logic         dsr_n_i,
   input  wire logic         ri_n_i,
   input  wire logic         cd_n_i,
   input  wire logic         ir_rx_i,
   input  wire logic         tx_thr_empty_i,
   input  wire logic         tx_idle_i,
   input  wire logic         tx_load_i,
   input  wire logic         bit_tick_i,
   output var  logic         rts_n_o,
   output var  logic         dtr_n_o,
   output var  logic         tx_pause_o,
   output var  logic         tx_int_o,
   output var  logic         modem_int_o,
   output var  logic         ir_rx_o,
   output var  logic [5:0]   hyst_chars_o
);
   import ums_pkg::*;

   // ************************************************************
   // State
   // ************************************************************

   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      ums_byte_t   scratch;
      ums_byte_t   feat;
      ums_byte_t   mctl;
      ums_byte_t   efeat;
      ums_byte_t   ien;
      ums_nib_t    dly;
      logic        rts_n;
      logic        dtr_n;
      logic        pause;
      logic        txint;
      logic        mint;
      logic        irrx;
      logic [5:0]  hyst;
   } ums_top_st_t;

   localparam ums_top_st_t RST_ST = '{
      ack:     1'b0,
      rdat:    32'h0000_0000,
      scratch: `UMS_SCRATCH_RST,
      feat:    `UMS_BYTE_RST,
      mctl:    `UMS_BYTE_RST,
      efeat:   `UMS_BYTE_RST,
      ien:     `UMS_BYTE_RST,
      dly:     `UMS_DLY_RST,
      rts_n:   1'b1,
      dtr_n:   1'b1,
      pause:   1'b0,
      txint:   1'b0,
      mint:    1'b0,
      irrx:    1'b0,
      hyst:    6'h00
   };

   // Hysteresis in characters, indexed by select code
   localparam logic [5:0] HYST_LUT [16] = '{
      6'h00, 6'h04, 6'h06, 6'h08,
      6'h08, 6'h10, 6'h18, 6'h20,
      6'h28, 6'h2C, 6'h30, 6'h34,
      6'h0C, 6'h14, 6'h1C, 6'h24
   };

   ums_top_st_t q_reg;
   ums_top_st_t q_next;
   ums_link_if  lk ();

   logic      req;
   logic      wr;
   logic      loop;
   ums_nib_t  st;
   ums_byte_t mstat;
   ums_byte_t stat;

   // ************************************************************
   // Submodules
   // ************************************************************

   ums_delta #(
      .N         (4),
      .FALL_ONLY (`UMS_FALL_ONLY)
   ) u_delta (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .lk    (lk.dlt)
   );

   ums_turn #(
      .DLY_W (4)
   ) u_turn (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .lk    (lk.trn)
   );

   // ************************************************************
   // Modem status
   // ************************************************************

   assign loop = q_reg.mctl[`UMS_MCTL_LOOP];

   always_comb
   begin
      if (loop)
      begin
         st[0] = q_reg.mctl[`UMS_MCTL_RTS];
         st[1] = q_reg.mctl[`UMS_MCTL_DTR];
         st[2] = q_reg.mctl[`UMS_MCTL_SEL];
         st[3] = q_reg.mctl[`UMS_MCTL_OUT3];
      end
      else
      begin
         st[0] = ~cts_n_i;
         st[1] = ~dsr_n_i;
         st[2] = ~ri_n_i;
         st[3] = ~cd_n_i;
      end
   end

   assign mstat = {st, lk.dflags};
   assign stat  = {1'b0, q_reg.pause, lk.t_state, q_reg.dly};

   // ************************************************************
   // Link to submodules
   // ************************************************************

   assign req       = wb_cyc_i & wb_stb_i & ~q_reg.ack;
   assign wr        = req & wb_we_i & wb_sel_i[0];
   assign lk.st     = st;
   assign lk.clr    = req & ~wb_we_i & (wb_adr_i == `UMS_ADR_MSTAT);
   assign lk.t_en   = q_reg.feat[`UMS_FEAT_RS485];
   assign lk.t_dly  = q_reg.dly;
   assign lk.t_idle = tx_idle_i;
   assign lk.t_load = tx_load_i;
   assign lk.t_tick = bit_tick_i;

   // ************************************************************
   // Next state
   // ************************************************************

   always_comb
   begin
      q_next     = q_reg;
      q_next.ack = req;

      // Read data; unmapped offsets answer zero
      if (req && !wb_we_i)
      begin
         if (wb_adr_i == `UMS_ADR_MSTAT)
            q_next.rdat = {24'h00_0000, mstat};
         else if (wb_adr_i == `UMS_ADR_SCRATCH)
            q_next.rdat = {24'h00_0000, q_reg.scratch};
         else if (wb_adr_i == `UMS_ADR_FEAT)
            q_next.rdat = {24'h00_0000, q_reg.feat};
         else if (wb_adr_i == `UMS_ADR_MCTL)
            q_next.rdat = {24'h00_0000, q_reg.mctl};
         else if (wb_adr_i == `UMS_ADR_EFEAT)
            q_next.rdat = {24'h00_0000, q_reg.efeat};
         else if (wb_adr_i == `UMS_ADR_IEN)
            q_next.rdat = {24'h00_0000, q_reg.ien};
         else if (wb_adr_i == `UMS_ADR_STAT)
            q_next.rdat = {24'h00_0000, stat};
         else
            q_next.rdat = 32'h0000_0000;
      end

      // Register writes
      if (wr)
      begin
         if (wb_adr_i == `UMS_ADR_MSTAT)
         begin
            // Legacy software cannot move the delay once enhanced mode is off
            if (q_reg.efeat[`UMS_EFEAT_ENH])
               q_next.dly = wb_dat_i[`UMS_DLY_LO +: 4];
         end
         else if (wb_adr_i == `UMS_ADR_SCRATCH)
            q_next.scratch = wb_dat_i[7:0];
         else if (wb_adr_i == `UMS_ADR_FEAT)
            q_next.feat = wb_dat_i[7:0];
         else if (wb_adr_i == `UMS_ADR_MCTL)
            q_next.mctl = wb_dat_i[7:0];
         else if (wb_adr_i == `UMS_ADR_EFEAT)
            q_next.efeat = wb_dat_i[7:0];
         else if (wb_adr_i == `UMS_ADR_IEN)
            q_next.ien = wb_dat_i[7:0];
      end

      // Modem interrupt, level while any flag stands
      q_next.mint = q_reg.ien[`UMS_IEN_MODEM] & (|lk.dflags);

      // Transmitter finishes its current character; it samples this between characters
      if (q_reg.mctl[`UMS_MCTL_SEL])
         q_next.pause = q_reg.efeat[`UMS_EFEAT_ACTS] & ~st[1];
      else
         q_next.pause = q_reg.efeat[`UMS_EFEAT_ACTS] & ~st[0];

      if (q_reg.feat[`UMS_FEAT_RS485])
         q_next.txint = tx_idle_i;
      else
         q_next.txint = tx_thr_empty_i;

      // Loopback keeps both modem outputs inactive
      if (loop)
      begin
         q_next.rts_n = 1'b1;
         q_next.dtr_n = 1'b1;
      end
      else
      begin
         if (q_reg.feat[`UMS_FEAT_RS485])
            q_next.rts_n = lk.t_drive;
         else
            q_next.rts_n = ~q_reg.mctl[`UMS_MCTL_RTS];
         q_next.dtr_n = ~q_reg.mctl[`UMS_MCTL_DTR];
      end

      q_next.irrx = ir_rx_i ^ q_reg.feat[`UMS_FEAT_IRINV];

      if (q_reg.feat[`UMS_FEAT_TBL_HI:`UMS_FEAT_TBL_LO] == `UMS_TBL_D)
         q_next.hyst = HYST_LUT[q_reg.feat[3:0]];
      else
         q_next.hyst = 6'h00;
   end

   // ************************************************************
   // Registers
   // ************************************************************

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q_reg <= RST_ST;
      else
         q_reg <= q_next;
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign wb_dat_o     = q_reg.rdat;
   assign wb_ack_o     = q_reg.ack;
   assign rts_n_o      = q_reg.rts_n;
   assign dtr_n_o      = q_reg.dtr_n;
   assign tx_pause_o   = q_reg.pause;
   assign tx_int_o     = q_reg.txint;
   assign modem_int_o  = q_reg.mint;
   assign ir_rx_o      = q_reg.irrx;
   assign hyst_chars_o = q_reg.hyst;

endmodule

`default_nettype wire

//--- ums_pkg.sv
`default_nettype none

package ums_pkg;

   typedef logic [7:0] ums_byte_t;
   typedef logic [3:0] ums_nib_t;

   typedef enum logic [1:0]
   {
      UMS_TURN_RX   = 2'b00,
      UMS_TURN_TX   = 2'b01,
      UMS_TURN_WAIT = 2'b10
   } ums_turn_state_t;

endpackage

`default_nettype wire

//--- ums_properties.sv
`include "ums_consts.svh"
`default_nettype none
module ums_properties
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        cts_n_i,
   input wire logic        dsr_n_i,
   input wire logic        ri_n_i,
   input wire logic        cd_n_i,
   input wire logic        ir_rx_i,
   input wire logic        tx_thr_empty_i,
   input wire logic        tx_idle_i,
   input wire logic        tx_load_i,
   input wire logic        rts_n_o,
   input wire logic        tx_pause_o,
   input wire logic        tx_int_o,
   input wire logic        modem_int_o,
   input wire logic        ir_rx_o,
   input wire logic [5:0]  hyst_chars_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import ums_pkg::*;
   // ****
   // Shadows
   // ****
   localparam logic [5:0] HYST [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18,
      6'h20, 6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
   ums_byte_t  mctl_reg;
   ums_byte_t  feat_reg;
   ums_byte_t  efeat_reg;
   logic       ien_reg;
   logic       take;
   logic [3:0] st_exp;
   logic       ir_exp;
   logic       txi_exp;
   logic       pz_exp;
   logic [5:0] hy_exp;
   // Writes land at the accepting edge, same as in the block
   assign take    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   assign st_exp  = mctl_reg[4] ? {mctl_reg[3:2], mctl_reg[0], mctl_reg[1]}
                                : ~{cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
   assign ir_exp  = ir_rx_i ^ feat_reg[4];
   assign txi_exp = feat_reg[5] ? tx_idle_i : tx_thr_empty_i;
   // Pause follows the status bits, so loopback substitutes apply here too
   assign pz_exp  = efeat_reg[7] & ~(mctl_reg[2] ? st_exp[1] : st_exp[0]);
   assign hy_exp  = (feat_reg[7:6] == 2'h3) ? HYST[feat_reg[3:0]] : 6'h00;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mctl_reg  <= 8'h00;
         feat_reg  <= 8'h00;
         efeat_reg <= 8'h00;
         ien_reg   <= 1'b0;
      end
      else if (take)
      begin
         if (wb_adr_i == `UMS_ADR_MCTL)
            mctl_reg <= wb_dat_i[7:0];
         if (wb_adr_i == `UMS_ADR_FEAT)
            feat_reg <= wb_dat_i[7:0];
         if (wb_adr_i == `UMS_ADR_EFEAT)
            efeat_reg <= wb_dat_i[7:0];
         if (wb_adr_i == `UMS_ADR_IEN)
            ien_reg <= wb_dat_i[3];
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");
   a_status_mirror:
      assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `UMS_ADR_MSTAT
         |-> wb_dat_o[7:4] == $past(st_exp)) else $error("status bits wrong");
   a_ir_polarity:
      assert property (!$past(rst_i) |-> ir_rx_o == $past(ir_exp)) else $error("ir level");
   a_tx_source:
      assert property (!$past(rst_i) |-> tx_int_o == $past(txi_exp)) else $error("tx int");
   a_pause_pair:
      assert property (!$past(rst_i) |-> tx_pause_o == $past(pz_exp)) else $error("pause");
   a_hyst_table:
      assert property ($stable(feat_reg) |-> hyst_chars_o == hy_exp) else $error("hyst");
   a_int_enable:
      assert property (modem_int_o |-> $past(ien_reg)) else $error("int while masked");
   a_rts_load:
      assert property (feat_reg[5] && tx_load_i |-> ##2 rts_n_o) else $error("rts late");
endmodule
`default_nettype wire

//--- ums_turn.sv
`include "ums_consts.svh"
`default_nettype none

module ums_turn
#(
   parameter int DLY_W = 4
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   ums_link_if.trn   lk
);
   import ums_pkg::*;

   if (DLY_W != 4)
   begin : g_chk
      $error("ums_turn delay field is four bits");
   end

   typedef struct packed {
      ums_turn_state_t  state;
      logic [DLY_W-1:0] cnt;
      logic             idle_prev;
   } ums_trn_st_t;

   ums_trn_st_t q_reg;
   ums_trn_st_t q_next;

   always_comb
   begin
      q_next           = q_reg;
      q_next.idle_prev = lk.t_idle;
      if (!lk.t_en)
      begin
         q_next.state = UMS_TURN_RX;
         q_next.cnt   = '0;
      end
      else if (lk.t_load)
      begin
         q_next.state = UMS_TURN_TX;
      end
      else
      begin
         case (q_reg.state)
            UMS_TURN_TX:
            begin
               // Rising idle only: a stale idle level right after a load is ignored
               if (lk.t_idle && !q_reg.idle_prev)
               begin
                  if (lk.t_dly == '0)
                     q_next.state = UMS_TURN_RX;
                  else
                  begin
                     q_next.state = UMS_TURN_WAIT;
                     q_next.cnt   = lk.t_dly;
                  end
               end
            end
            UMS_TURN_WAIT:
            begin
               if (lk.t_tick)
               begin
                  if (q_reg.cnt == DLY_W'(1))
                     q_next.state = UMS_TURN_RX;
                  q_next.cnt = q_reg.cnt - DLY_W'(1);
               end
            end
            default:
            begin
               q_next.state = UMS_TURN_RX;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q_reg <= '{state: UMS_TURN_RX, cnt: '0, idle_prev: 1'b1};
      else
         q_reg <= q_next;
   end

   assign lk.t_drive = (q_reg.state != UMS_TURN_RX);
   assign lk.t_state = q_reg.state;

endmodule

`default_nettype wire
